// File: rtl/pct_pkg.sv
// package for the quad pwm / capture timer block
// assumes a 32-bit axi4-lite register bus and one 100 MHz clock
package pct_pkg;
   // register byte offsets
   localparam logic [7:0] PRESCALE_OFS = 8'h00; // prescalers of the four generator sets
   localparam logic [7:0] DIVSEL_OFS = 8'h04; // divider selects, 4 bits per timer
   localparam logic [7:0] PWM_CONTROL_OFS = 8'h08; // pwm_control
   localparam logic [7:0] CAPTURE_CONTROL_CH01_OFS = 8'h0C; // capture_control_ch01
   localparam logic [7:0] IRQ_ENABLE_OFS = 8'h1C; // period interrupt enables
   localparam logic [7:0] IRQ_FLAG_OFS = 8'h20; // period flags, write one to clear
   localparam logic [7:0] DEAD_TIME_OFS = 8'h24; // dead times, 8 bits per pair
   localparam logic [7:0] PERIOD_RELOAD_VALUE_OFS = 8'h40; // 8 words, period buffers
   localparam logic [7:0] COMPARE_OFS = 8'h60; // 8 words, compare buffers
   localparam logic [7:0] COUNT_OFS = 8'h80; // 8 words, live counts (read only)
   localparam logic [7:0] RISING_CAPTURE_LATCH_OFS = 8'hA0; // 8 words
   localparam logic [7:0] FALLING_CAPTURE_LATCH_OFS = 8'hC0; // 8 words
   // pwm_control layout, one nibble per timer: enable, continuous, invert; bit 3 dead-zone
   localparam int CTL_RUN_BIT = 0;
   localparam int CTL_CONT_BIT = 1;
   localparam int CTL_INV_BIT = 2;
   localparam int CTL_DZEN_BIT = 3;
   // capture control layout, one half word per channel
   localparam int CAP_INV_BIT = 0;
   localparam int CAP_RISE_IE_BIT = 1;
   localparam int CAP_FALL_IE_BIT = 2;
   localparam int CAP_EN_BIT = 3;
   localparam int CAP_IRQ_FLAG_BIT = 4;
   localparam int CAP_RISE_SEEN_BIT = 6;
   localparam int CAP_FALL_SEEN_BIT = 7;
   // reset values
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   // divider codes: 0 -> /2, 1 -> /4, 2 -> /8, 3 -> /16, 4 -> /1
   localparam logic [2:0] DIV_BY1_CODE = 3'h4;
   localparam int AXI_OKAY = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/pct_top.sv
// quad pwm generator and capture timer with an axi4-lite register slave
// assumes capture inputs already synchronous to clock; pins are driven while pwm, released in capture
// Functional notes
// R1 - four sets, eight channels or four pairs
// R2 - 8-bit prescaler then divider 1..16 per timer
// R3 - two 16-bit down-counters, comparators, one dead-zone
// R4 - period flag set when counter reaches zero
// R5 - interrupt only when flag's enable set
// R6 - dead-zone enable pairs outputs 0,1 off timer 0
// R7 - pairs 2-3,4-5,6-7 use timers 2,4,6
// R8 - buffers load into counter/comparator at zero
// R9 - continuous mode reloads period and repeats
// R10 - one-shot halts at zero, one interrupt
// R11 - output toggles when count equals compare
// R12 - capture enable turns pin into input
// R13 - capture channel n uses timer n
// R14 - software sets timer before enabling capture
// R15 - rising edge latches count into rising latch
// R16 - falling edge latches count into falling latch
// R17 - separate rising/falling capture interrupt enables
// R18 - capture interrupt reloads the timer counter
// R19 - each channel has latches and flag
// R20 - dead time delays both active edges
// R21 - capture flag sticky until software clears
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module pct_top (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [7:0] pwm_in, // pin inputs, used in capture mode
   output logic [7:0] pwm_out_0_to_7, // pin outputs
   output logic [7:0] pwm_oe_n, // low while the block drives the pin
   output logic pwm_irq // period or capture interrupt request
);
   // ---------------- register state ----------------
   logic [31:0] prescale_reg, prescale_next; // R2
   logic [31:0] divsel_reg, divsel_next;
   logic [31:0] ctl_reg, ctl_next;
   logic [7:0] ien_reg, ien_next;
   logic [31:0] dead_reg, dead_next;
   logic [15:0] cap_ctl_reg [0:7]; // capture control per channel
   logic [15:0] cap_ctl_next [0:7];
   logic [15:0] per_buf_reg [0:7]; // period buffers
   logic [15:0] per_buf_next [0:7];
   logic [15:0] cmp_buf_reg [0:7]; // compare buffers
   logic [15:0] cmp_buf_next [0:7];
   // bus handshake state
   logic aw_held_reg, aw_held_next;
   logic [7:0] aw_addr_reg, aw_addr_next;
   logic w_held_reg, w_held_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   // timer state
   logic [7:0] pre_cnt_reg [0:3]; // prescaler counters
   logic [7:0] pre_cnt_next [0:3];
   logic [3:0] div_cnt_reg [0:3]; // divider counters, shared by both timers of a set
   logic [3:0] div_cnt_next [0:3];
   logic [15:0] cnt_reg [0:7];
   logic [15:0] cnt_next [0:7];
   logic [15:0] cmp_reg [0:7]; // active compare values
   logic [15:0] cmp_next [0:7];
   logic [7:0] lvl_reg, lvl_next; // raw pwm levels
   logic [7:0] pflag_reg, pflag_next; // period flags
   logic [7:0] in_d_reg, in_d_next; // previous capture input
   logic [15:0] rise_lat_reg [0:7];
   logic [15:0] rise_lat_next [0:7];
   logic [15:0] fall_lat_reg [0:7];
   logic [15:0] fall_lat_next [0:7];
   logic [7:0] dz_cnt_reg [0:7]; // dead-time counters, one per output
   logic [7:0] dz_cnt_next [0:7];
   logic [7:0] out_reg, out_next;
   // write decode signals
   logic wr_go;
   logic [7:0] wa;
   logic [31:0] wd;
   logic pre_tick [0:3];
   logic [7:0] tick;
   logic [7:0] zero_hit;
   logic [7:0] done_reg, done_next; // one-shot timers parked at zero
   localparam logic [7:0] COUNT_OFS_L = pct_pkg::COUNT_OFS;
   localparam logic [7:0] DEAD_TIME_OFS_L = pct_pkg::DEAD_TIME_OFS;
   localparam logic [7:0] PER_OFS_L = pct_pkg::PERIOD_RELOAD_VALUE_OFS;

   // the write fires once both address and data are held and no response waits
   always_comb begin
      wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
      wa = aw_addr_reg;
      wd = w_data_reg;
   end

   // ---------------- axi4-lite handshake ----------------
   // one write and one read in flight; ready is low while a beat is held
   always_comb begin
      awready = !aw_held_reg;
      wready = !w_held_reg;
      arready = !rvalid_reg;
      bvalid = bvalid_reg;
      bresp = bresp_reg;
      rvalid = rvalid_reg;
      rdata = rdata_reg;
      rresp = rresp_reg;
      aw_held_next = aw_held_reg;
      aw_addr_next = aw_addr_reg;
      w_held_next = w_held_reg;
      w_data_next = w_data_reg;
      w_strb_next = w_strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      if (awvalid && !aw_held_reg) begin
         aw_held_next = 1'b1;
         aw_addr_next = awaddr;
      end
      if (wvalid && !w_held_reg) begin
         w_held_next = 1'b1;
         w_data_next = wdata;
         w_strb_next = wstrb;
      end
      if (wr_go) begin
         aw_held_next = 1'b0;
         w_held_next = 1'b0;
         bvalid_next = 1'b1;
         // count and latch words are read only, unmapped answers slverr
         if (wa[1:0] != 2'h0 || wa >= COUNT_OFS_L || (wa > DEAD_TIME_OFS_L && wa < PER_OFS_L)) begin
            bresp_next = pct_pkg::RESP_SLVERR;
         end else begin
            bresp_next = pct_pkg::RESP_OKAY;
         end
      end else if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
   end

   // read mux; flags and latches show the block's own state
   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (arvalid && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rresp_next = pct_pkg::RESP_OKAY;
         rdata_next = 32'h0000_0000;
         if (araddr == pct_pkg::PRESCALE_OFS) begin
            rdata_next = prescale_reg;
         end else if (araddr == pct_pkg::DIVSEL_OFS) begin
            rdata_next = divsel_reg;
         end else if (araddr == pct_pkg::PWM_CONTROL_OFS) begin
            rdata_next = ctl_reg;
         end else if (araddr >= pct_pkg::CAPTURE_CONTROL_CH01_OFS && araddr < 8'h1C
                      && araddr[1:0] == 2'h0) begin
            rdata_next = {cap_ctl_reg[{araddr[3:2] - 2'h3, 1'b1}],
                          cap_ctl_reg[{araddr[3:2] - 2'h3, 1'b0}]};
         end else if (araddr == pct_pkg::IRQ_ENABLE_OFS) begin
            rdata_next = {24'h00_0000, ien_reg};
         end else if (araddr == pct_pkg::IRQ_FLAG_OFS) begin
            rdata_next = {24'h00_0000, pflag_reg};
         end else if (araddr == pct_pkg::DEAD_TIME_OFS) begin
            rdata_next = dead_reg;
         end else if (araddr[1:0] == 2'h0 && araddr >= PER_OFS_L && araddr < 8'hE0) begin
            case (araddr[7:5])
               3'h2: rdata_next = {16'h0000, per_buf_reg[araddr[4:2]]};
               3'h3: rdata_next = {16'h0000, cmp_buf_reg[araddr[4:2]]};
               3'h4: rdata_next = {16'h0000, cnt_reg[araddr[4:2]]};
               3'h5: rdata_next = {16'h0000, rise_lat_reg[araddr[4:2]]};
               default: rdata_next = {16'h0000, fall_lat_reg[araddr[4:2]]};
            endcase
         end else begin
            rresp_next = pct_pkg::RESP_SLVERR; // unmapped address
         end
      end else if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
   end

   // ---------------- control register writes ----------------
   // byte enables honoured on the wide control words
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   always_comb begin
      prescale_next = prescale_reg;
      divsel_next = divsel_reg;
      ctl_next = ctl_reg;
      ien_next = ien_reg;
      dead_next = dead_reg;
      if (wr_go && wa == pct_pkg::PRESCALE_OFS) begin
         prescale_next = merge(prescale_reg, wd, w_strb_reg);
      end else if (wr_go && wa == pct_pkg::DIVSEL_OFS) begin
         divsel_next = merge(divsel_reg, wd, w_strb_reg);
      end else if (wr_go && wa == pct_pkg::PWM_CONTROL_OFS) begin
         ctl_next = merge(ctl_reg, wd, w_strb_reg);
      end else if (wr_go && wa == pct_pkg::IRQ_ENABLE_OFS && w_strb_reg[0]) begin
         ien_next = wd[7:0];
      end else if (wr_go && wa == pct_pkg::DEAD_TIME_OFS) begin
         dead_next = merge(dead_reg, wd, w_strb_reg);
      end
   end

   // ---------------- prescaler and divider per generator set ----------------
   for (genvar s = 0; s < 4; s++) begin : g_set
      always_comb begin
         pre_tick[s] = (pre_cnt_reg[s] == 8'h00); // R2
         pre_cnt_next[s] = pre_tick[s] ? prescale_reg[s*8 +: 8] : pre_cnt_reg[s] - 8'h01;
         div_cnt_next[s] = pre_tick[s] ? div_cnt_reg[s] + 4'h1 : div_cnt_reg[s];
      end
   end

   // ---------------- per-channel timer, compare, capture, dead zone ----------------
   for (genvar c = 0; c < 8; c++) begin : g_ch
      logic [2:0] dsel;
      logic run, cont, inv, cap_en, rise, fall, cap_irq, pair_dz, src_lvl, want;
      logic [15:0] cc_w;
      always_comb begin
         dsel = divsel_reg[c*4 +: 3];
         run = ctl_reg[c*4 + pct_pkg::CTL_RUN_BIT];
         cont = ctl_reg[c*4 + pct_pkg::CTL_CONT_BIT];
         inv = ctl_reg[c*4 + pct_pkg::CTL_INV_BIT];
         cap_en = cap_ctl_reg[c][pct_pkg::CAP_EN_BIT];
         // clock selector: divider bit edge, or every prescaler tick for /1
         if (dsel == pct_pkg::DIV_BY1_CODE) begin
            tick[c] = pre_tick[c/2] && run; // R2
         end else begin
            tick[c] = pre_tick[c/2] && run && (div_cnt_reg[c/2] & ((4'h2 << dsel) - 4'h1)) == 4'h0;
         end
         zero_hit[c] = tick[c] && cnt_reg[c] == 16'h0000 && !done_reg[c]; // R4 R10
         rise = cap_en && pwm_in[c] && !in_d_reg[c]; // R15
         fall = cap_en && !pwm_in[c] && in_d_reg[c]; // R16
         cap_irq = (rise && cap_ctl_reg[c][pct_pkg::CAP_RISE_IE_BIT])
                   || (fall && cap_ctl_reg[c][pct_pkg::CAP_FALL_IE_BIT]); // R17
         in_d_next[c] = pwm_in[c];
         // counter: reload on zero or on capture interrupt, halt in one-shot
         cnt_next[c] = cnt_reg[c];
         cmp_next[c] = cmp_reg[c];
         lvl_next[c] = lvl_reg[c];
         if (!run) begin
            cnt_next[c] = per_buf_reg[c];
            cmp_next[c] = cmp_buf_reg[c];
            lvl_next[c] = 1'b0;
         end else if (cap_irq) begin
            cnt_next[c] = per_buf_reg[c]; // R18
         end else if (zero_hit[c]) begin
            cmp_next[c] = cmp_buf_reg[c]; // R8
            lvl_next[c] = 1'b0;
            if (cont) begin
               cnt_next[c] = per_buf_reg[c]; // R9 R8
            end
         end else if (tick[c] && !(cnt_reg[c] == 16'h0000 && !cont)) begin
            cnt_next[c] = cnt_reg[c] - 16'h0001; // R3 R10
            if (cnt_reg[c] - 16'h0001 == cmp_reg[c]) begin
               lvl_next[c] = 1'b1; // R11
            end
         end
         // one-shot: once parked, no further zero hits, so exactly one flag
         done_next[c] = (done_reg[c] || (zero_hit[c] && !cont)) && run; // R10
         pflag_next[c] = pflag_reg[c];
         if (wr_go && wa == pct_pkg::IRQ_FLAG_OFS && wd[c]) begin
            pflag_next[c] = 1'b0;
         end
         if (zero_hit[c]) begin
            pflag_next[c] = 1'b1; // R4 R10 set wins over clear
         end
         // latches, flag and capture control register
         rise_lat_next[c] = rise ? cnt_reg[c] : rise_lat_reg[c]; // R15 R13 R19
         fall_lat_next[c] = fall ? cnt_reg[c] : fall_lat_reg[c]; // R16 R19
         cc_w = c[0] ? wd[31:16] : wd[15:0];
         cap_ctl_next[c] = cap_ctl_reg[c];
         if (wr_go && wa == pct_pkg::CAPTURE_CONTROL_CH01_OFS + 8'(4 * (c / 2))) begin
            cap_ctl_next[c][3:0] = cc_w[3:0];
            // write one clears sticky bits
            cap_ctl_next[c][7:4] = cap_ctl_reg[c][7:4] & ~cc_w[7:4]; // R21
         end
         if (cap_irq) begin
            cap_ctl_next[c][pct_pkg::CAP_IRQ_FLAG_BIT] = 1'b1; // R21 R19
         end
         if (rise) begin
            cap_ctl_next[c][pct_pkg::CAP_RISE_SEEN_BIT] = 1'b1;
         end
         if (fall) begin
            cap_ctl_next[c][pct_pkg::CAP_FALL_SEEN_BIT] = 1'b1;
         end
         // buffer registers
         per_buf_next[c] = per_buf_reg[c];
         cmp_buf_next[c] = cmp_buf_reg[c];
         if (wr_go && wa == pct_pkg::PERIOD_RELOAD_VALUE_OFS + 8'(4 * c)) begin
            per_buf_next[c] = wd[15:0];
         end
         if (wr_go && wa == pct_pkg::COMPARE_OFS + 8'(4 * c)) begin
            cmp_buf_next[c] = wd[15:0];
         end
         // complementary pairs take the even timer; odd output is its inverse
         pair_dz = ctl_reg[(c/2)*8 + pct_pkg::CTL_DZEN_BIT]; // R6 R7
         src_lvl = (pair_dz && c[0]) ? !lvl_reg[c-c%2] : lvl_reg[pair_dz ? c-c%2 : c];
         want = src_lvl ^ inv;
         // dead time: a rising edge waits out the programmed count
         dz_cnt_next[c] = dz_cnt_reg[c];
         out_next[c] = out_reg[c];
         if (!pair_dz || !want) begin
            out_next[c] = pair_dz ? 1'b0 : want; // R1
            dz_cnt_next[c] = dead_reg[(c/2)*8 +: 8];
         end else if (dz_cnt_reg[c] == 8'h00) begin
            out_next[c] = 1'b1; // R20
         end else begin
            dz_cnt_next[c] = dz_cnt_reg[c] - 8'h01; // R20
         end
         pwm_oe_n[c] = cap_en; // R12
      end
   end

   // interrupt request from enabled period flags or any capture flag
   always_comb begin
      pwm_irq = |(pflag_reg & ien_reg); // R5
      for (int c = 0; c < 8; c++) begin
         pwm_irq = pwm_irq | cap_ctl_reg[c][pct_pkg::CAP_IRQ_FLAG_BIT];
      end
      pwm_out_0_to_7 = out_reg;
   end

   // ---------------- registers ----------------
   always_ff @(posedge clock) begin
      if (rst) begin
         prescale_reg <= pct_pkg::REG_RESET;
         divsel_reg <= pct_pkg::REG_RESET;
         ctl_reg <= pct_pkg::REG_RESET;
         ien_reg <= 8'h00;
         dead_reg <= pct_pkg::REG_RESET;
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'h0;
         lvl_reg <= 8'h00;
         pflag_reg <= 8'h00;
         in_d_reg <= 8'h00;
         out_reg <= 8'h00;
         done_reg <= 8'h00;
         for (int i = 0; i < 4; i++) begin
            pre_cnt_reg[i] <= 8'h00;
            div_cnt_reg[i] <= 4'h0;
         end
         for (int i = 0; i < 8; i++) begin
            cap_ctl_reg[i] <= 16'h0000;
            per_buf_reg[i] <= pct_pkg::CNT_RESET;
            cmp_buf_reg[i] <= pct_pkg::CNT_RESET;
            cnt_reg[i] <= pct_pkg::CNT_RESET;
            cmp_reg[i] <= pct_pkg::CNT_RESET;
            rise_lat_reg[i] <= pct_pkg::CNT_RESET;
            fall_lat_reg[i] <= pct_pkg::CNT_RESET;
            dz_cnt_reg[i] <= 8'h00;
         end
      end else begin
         prescale_reg <= prescale_next;
         divsel_reg <= divsel_next;
         ctl_reg <= ctl_next;
         ien_reg <= ien_next;
         dead_reg <= dead_next;
         aw_held_reg <= aw_held_next;
         aw_addr_reg <= aw_addr_next;
         w_held_reg <= w_held_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         lvl_reg <= lvl_next;
         pflag_reg <= pflag_next;
         in_d_reg <= in_d_next;
         out_reg <= out_next;
         done_reg <= done_next;
         pre_cnt_reg <= pre_cnt_next;
         div_cnt_reg <= div_cnt_next;
         cap_ctl_reg <= cap_ctl_next;
         per_buf_reg <= per_buf_next;
         cmp_buf_reg <= cmp_buf_next;
         cnt_reg <= cnt_next;
         cmp_reg <= cmp_next;
         rise_lat_reg <= rise_lat_next;
         fall_lat_reg <= fall_lat_next;
         dz_cnt_reg <= dz_cnt_next;
      end
   end
endmodule

// File: verification/pct_props.sv
// checker for the bus handshakes and reset state of the pwm / capture block
// assumes it is bound to pct_top and sees only its ports
`timescale 1ns/100ps
module pct_props (
   input wire logic clock,
   input wire logic rst,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [7:0] pwm_out_0_to_7,
   input wire logic [7:0] pwm_oe_n,
   input wire logic pwm_irq
);
   // one clock domain, so one clocking and one disable for all
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_b_hold; bvalid && !bready |=> bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response withdrawn");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read response changed");
   property p_ar_busy; rvalid |-> !arready; endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read address taken while busy");
   property p_ar_ans; arvalid && arready |=> rvalid; endproperty
   a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
   // both halves taken together: answer two edges later
   property p_w_ans; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
   a_w_ans: assert property (p_w_ans) else $error("write answer late");
   property p_aw_held; awvalid && awready |=> !awready; endproperty
   a_aw_held: assert property (p_aw_held) else $error("second address taken");
   property p_w_held; wvalid && wready |=> !wready; endproperty
   a_w_held: assert property (p_w_held) else $error("second data taken");
   property p_b_done; bvalid && bready |=> !bvalid; endproperty
   a_b_done: assert property (p_b_done) else $error("write response repeated");
   // pins come out of reset driven and low, with no request
   property p_rst; $fell(rst) |-> pwm_out_0_to_7 == 8'h00 && pwm_oe_n == 8'h00 && !pwm_irq;
   endproperty
   a_rst: assert property (p_rst) else $error("pins not idle after reset");
   c_write: cover property (bvalid && bready);
   c_read: cover property (rvalid && rready);
   c_irq: cover property ($rose(pwm_irq));
endmodule
bind pct_top pct_props props_u (.*);

// File: verification/pct_stage.sv
// far-side model: capture sources sharing the pwm pins
// assumes the block drives a pin while its enable is low
`timescale 1ns/100ps
module pct_stage (
   input wire logic [7:0] pwm_out_0_to_7,
   input wire logic [7:0] pwm_oe_n,
   input wire logic [7:0] src_level,
   output logic [7:0] pwm_in
);
   // pin level: block output while driven, capture source once released
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pwm_in[i] = pwm_oe_n[i] ? src_level[i] : pwm_out_0_to_7[i];
      end
   end
endmodule

// File: verification/testbench.sv
// self-checking bench for the quad pwm / capture block
// assumes pct_stage as the capture source on the pins
`timescale 1ns/100ps
module testbench;
   localparam logic [1:0] OK = pct_pkg::RESP_OKAY;
   localparam logic [7:0] CTL = pct_pkg::PWM_CONTROL_OFS;
   localparam logic [7:0] DIV = pct_pkg::DIVSEL_OFS;
   localparam logic [7:0] PER = pct_pkg::PERIOD_RELOAD_VALUE_OFS;
   localparam logic [7:0] CMP = pct_pkg::COMPARE_OFS;
   localparam logic [7:0] CAP = pct_pkg::CAPTURE_CONTROL_CH01_OFS;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, src = 8'h00, seen = 8'h00, both = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, pwm_irq;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [7:0] pwm_in, pwm_out_0_to_7, pwm_oe_n;
   int num_errors = 0, num_checks = 0, hi, per, i, j;
   always #5 clock = ~clock;
   pct_top dut_u (.*);
   pct_stage stage_u (.pwm_out_0_to_7, .pwm_oe_n, .src_level(src), .pwm_in);
   // verdict and end of run
   task automatic test_done();
      if (num_errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // case-equal compare, counted
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // a wait that ran out counts as a mismatch
   task automatic hang();
      num_errors++;
      $display("[ERR] %0t wait ran out", $time);
      test_done();
   endtask
   // handshakes judged at the falling edge, so the rising edge sees the same values
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
      logic pa, pw, tb;
      tb = 1'b0;
      @(posedge clock);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; !tb; n++) begin
         if (n > 200) hang();
         @(negedge clock);
         pa = awvalid && awready;
         pw = wvalid && wready;
         tb = bvalid;
         @(posedge clock);
         if (pa) awvalid <= 1'b0;
         if (pw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
      chk(bresp, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      logic pa, tb;
      tb = 1'b0;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; !tb; n++) begin
         if (n > 200) hang();
         @(negedge clock);
         pa = arvalid && arready;
         tb = rvalid;
         v = rdata;
         e = rresp;
         @(posedge clock);
         if (pa) arvalid <= 1'b0;
         if (tb) rready <= 1'b0;
      end
   endtask
   // waits for a pin level, counting cycles
   task automatic wt(input int ch, input logic lv, output int c);
      for (c = 0; pwm_out_0_to_7[ch] !== lv; c++) begin
         if (c > 3000) hang();
         @(negedge clock);
      end
   endtask
   // one whole cycle: high time and rise-to-rise period
   task automatic meas(input int ch);
      wt(ch, 1'b0, hi);
      wt(ch, 1'b1, hi);
      wt(ch, 1'b0, hi);
      wt(ch, 1'b1, per);
      per = per + hi;
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      chk(pwm_oe_n, 8'h00);
      // reset value, unmapped and read-only places
      rd(CTL, d, r);
      chk(d, pct_pkg::REG_RESET);
      wr(8'h30, 32'h00000005, pct_pkg::RESP_SLVERR);
      rd(8'h30, d, r);
      chk(d, 32'h00000000);
      chk(r, pct_pkg::RESP_SLVERR);
      wr(pct_pkg::COUNT_OFS, 32'h00000005, pct_pkg::RESP_SLVERR);
      // divider codes 0 to 4, prescaler 2, period 3, compare 1
      wr(pct_pkg::PRESCALE_OFS, 32'h00000002, OK);
      wr(PER, 32'h00000003, OK);
      wr(CMP, 32'h00000001, OK);
      for (i = 0; i < 5; i++) begin
         wr(CTL, 32'h00000000, OK);
         wr(DIV, 32'(i), OK);
         wr(CTL, 32'h00000003, OK);
         meas(0);
         j = (i == 4) ? 1 : 2 << i;
         chk(per, 12 * j);
         chk(hi, 6 * j);
      end
      // period flag reaches the request line only when enabled
      chk(pwm_irq, 1'b0);
      rd(pct_pkg::IRQ_FLAG_OFS, d, r);
      chk(d[0], 1'b1);
      wr(pct_pkg::IRQ_ENABLE_OFS, 32'h00000001, OK);
      chk(pwm_irq, 1'b1);
      wr(pct_pkg::IRQ_ENABLE_OFS, 32'h00000000, OK);
      // a new period waits for the count to pass zero
      wr(PER, 32'h00000032, OK);
      rd(pct_pkg::COUNT_OFS, d, r);
      chk(d < 32'h00000004, 1'b1);
      meas(0);
      chk(per, 153);
      // one-shot on timer 1: a single pulse, then the count rests at zero
      wr(CTL, 32'h00000000, OK);
      wr(DIV, 32'h00000044, OK);
      wr(PER + 8'h04, 32'h00000007, OK);
      wr(CMP + 8'h04, 32'h00000003, OK);
      wr(CTL, 32'h00000010, OK);
      j = 0;
      for (i = 0; i < 200; i++) begin
         @(negedge clock);
         j += int'(pwm_out_0_to_7[1] && !seen[1]);
         seen[1] = pwm_out_0_to_7[1];
      end
      chk(j, 1);
      rd(pct_pkg::COUNT_OFS + 8'h04, d, r);
      chk(d, 32'h00000000);
      wr(CTL, 32'h00000000, OK);
      // four complementary pairs off the even timers, dead time 3
      for (i = 0; i < 8; i += 2) begin
         wr(PER + 8'(4 * i), 32'h00000014, OK);
         wr(CMP + 8'(4 * i), 32'h0000000A, OK);
      end
      wr(DIV, 32'h44444444, OK);
      wr(pct_pkg::DEAD_TIME_OFS, 32'h03030303, OK);
      wr(CTL, 32'h0B0B0B0B, OK);
      seen = 8'h00;
      for (i = 0; i < 400; i++) begin
         @(negedge clock);
         seen = seen | pwm_out_0_to_7;
         both = both | (pwm_out_0_to_7 & {pwm_out_0_to_7[6:0], 1'b0});
      end
      chk(seen, 8'hFF);
      chk(both & 8'hAA, 8'h00);
      wr(CTL, 32'h00000000, OK);
      // capture on channel 2, its timer parked at period 200, timer 3 at 77
      wr(PER + 8'h08, 32'h000000C8, OK);
      wr(PER + 8'h0C, 32'h0000004D, OK);
      wr(CAP + 8'h04, 32'h0000000A, OK);
      chk(pwm_oe_n, 8'h04);
      src <= 8'h04;
      for (i = 0; pwm_irq !== 1'b1; i++) begin
         if (i > 50) hang();
         @(negedge clock);
      end
      rd(pct_pkg::RISING_CAPTURE_LATCH_OFS + 8'h08, d, r);
      chk(d, 32'h000000C8);
      rd(pct_pkg::RISING_CAPTURE_LATCH_OFS + 8'h0C, d, r);
      chk(d, 32'h00000000);
      chk(pwm_irq, 1'b1);
      wr(CAP + 8'h04, 32'h0000001A, OK);
      chk(pwm_irq, 1'b0);
      src <= 8'h00;
      repeat (4) @(posedge clock);
      rd(pct_pkg::FALLING_CAPTURE_LATCH_OFS + 8'h08, d, r);
      chk(d, 32'h000000C8);
      chk(pwm_irq, 1'b0);
      test_done();
   end
endmodule
